// ==== logic/wsf_pkg.sv ====
// wake-source flag logic: constants, field positions and carrier types
// assumes a 40 MHz mclk_i and a byte-wide processor register port
package wsf_pkg;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'h28B0;
  localparam logic [15:0] ADDR_WAKE_CAUSE = 16'h28B1;
  localparam logic [15:0] ADDR_MODE_ARM = 16'h28B2;
  localparam logic [15:0] ADDR_WAKE_EN = 16'h28B3;
  localparam logic [15:0] ADDR_TIMER_VALUE = 16'h2880;
  // reset-cause bits
  localparam int RC_COLD = 7;
  localparam int RC_PIN = 6;
  localparam int RC_SOFT = 5;
  localparam int RC_WDOG = 4;
  localparam int RC_DEBUG = 3;
  localparam int RC_BATT = 2;
  // wake-cause bits
  localparam int WC_TIMER = 5;
  localparam int WC_SERIAL = 4;
  localparam int WC_BUTTON = 3;
  localparam int WC_PIN4 = 2;
  localparam int WC_PIN52 = 1;
  localparam int WC_PIN55 = 0;
  // mode-control bits
  localparam int MC_SLEEP = 7;
  localparam int MC_DISPLAY = 6;
  localparam int MC_ARM = 5;
  // enable bits
  localparam int EN_SERIAL = 4;
  localparam int EN_BUTTON = 3;
  localparam int EN_PIN4 = 2;
  localparam int EN_PIN52 = 1;
  localparam int EN_PIN55 = 0;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_TIMER_VALUE = 8'h00;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SAMPLE_MS = 2;
  localparam int DEBOUNCE_MS = 64;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int DEBOUNCE_SAMPLES = DEBOUNCE_MS / SAMPLE_MS;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_CYCLES = CLK_HZ / SLOW_HZ;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int RELEASE_SLOW_TICKS = 3;
  localparam int RELEASE_CYCLES = RELEASE_SLOW_TICKS * SLOW_CYCLES;

  typedef struct packed {
    logic cold_start;
    logic reset_pin;
    logic soft_reset;
    logic watchdog;
    logic debug_reset;
    logic low_battery;
  } wsf_reset_src_type;

  typedef struct packed {
    logic multi_pin_4;
    logic multi_pin_52;
    logic multi_pin_55;
    logic pushbutton_input;
    logic serial_receive;
    logic optical_receive_input;
  } wsf_pins_type;

  typedef struct packed {
    logic pin4_digital_in;
    logic pin52_digital_in;
    logic pin55_digital_in;
    logic optical_receive_disable;
  } wsf_pin_cfg_type;
endpackage : wsf_pkg

// ==== logic/wsf_top.sv ====
// wake-source enables, wake/reset cause flags, debounce, wake timer, resume
// assumes inputs synchronous to mclk_i and reset-source pulses one cycle wide
`timescale 1ns/1ps
module wsf_top (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire wsf_pkg::wsf_reset_src_type reset_src_i,
  input wire logic debug_port_enable_pin_i,
  input wire wsf_pkg::wsf_pins_type pins_i,
  input wire wsf_pkg::wsf_pin_cfg_type pin_cfg_i,
  output logic resume_o,
  output logic cpu_release_o,
  output logic low_power_o
);
  import wsf_pkg::*;

  typedef enum logic [1:0] {ST_AWAKE, ST_ASLEEP, ST_RELEASING} wsf_state_type;

  function automatic logic [4:0] step5(input logic [4:0] v);
    step5 = v + 5'h01;
  endfunction : step5

  logic [7:0] enables_ff;
  logic arm_ff;
  logic [7:0] timer_value_ff;
  logic [5:0] reset_flags_ff;
  logic [5:0] wake_flags_ff;
  logic resume_ff;
  wsf_state_type state_ff;
  logic [7:0] rdata_ff;
  logic [16:0] sample_cnt_ff;
  logic [4:0] db52_ff;
  logic [4:0] db55_ff;
  logic [4:0] db_btn_ff;
  logic hi52_ff;
  logic hi55_ff;
  logic hi_btn_ff;
  logic pin4_prev_ff;
  logic serial_prev_ff;
  logic optical_prev_ff;
  logic [7:0] timer_secs_ff;
  logic [25:0] sec_cnt_ff;
  logic timer_run_ff;
  logic [11:0] release_cnt_ff;

  logic wr_mode;
  logic sleep_req;
  logic sample_tick;
  logic ev_pin4;
  logic ev_pin52;
  logic ev_pin55;
  logic ev_button;
  logic ev_serial;
  logic ev_timer;
  logic any_wake;
  logic resume_fall;
  logic dbg_rst;

  assign wr_mode = wr_i && (addr_i == ADDR_MODE_ARM);
  assign sleep_req = wr_mode && (wdata_i[MC_SLEEP] || wdata_i[MC_DISPLAY]);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      enables_ff <= RST_ENABLES;
    end else if (wr_i && addr_i == ADDR_WAKE_EN) begin
      enables_ff <= {3'h0, wdata_i[4:0]};
    end
  end

  // timer value would be non-volatile in silicon; here only reset restores it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      timer_value_ff <= RST_TIMER_VALUE;
    end else if (wr_i && addr_i == ADDR_TIMER_VALUE) begin
      timer_value_ff <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      arm_ff <= RST_MODE[MC_ARM];
    end else if (wr_mode) begin
      arm_ff <= wdata_i[MC_ARM];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_RESET_CAUSE: rdata_ff <= {reset_flags_ff[5:1], reset_flags_ff[0], 2'b00};
        ADDR_WAKE_CAUSE: rdata_ff <= {2'b00, wake_flags_ff};
        ADDR_MODE_ARM: rdata_ff <= {2'b00, arm_ff, 5'h00};
        ADDR_WAKE_EN: rdata_ff <= enables_ff;
        ADDR_TIMER_VALUE: rdata_ff <= timer_value_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // debounce of level pins

  assign sample_tick = (sample_cnt_ff == 17'(SAMPLE_CYCLES - 1));

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || sample_tick) begin
      sample_cnt_ff <= 17'h00000;
    end else begin
      sample_cnt_ff <= sample_cnt_ff + 17'h00001;
    end
  end

  // one sample low restarts the count: a glitch costs a full 64 ms again
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      db52_ff <= 5'h00;
      db55_ff <= 5'h00;
      db_btn_ff <= 5'h00;
      hi52_ff <= 1'b0;
      hi55_ff <= 1'b0;
      hi_btn_ff <= 1'b0;
    end else if (sample_tick) begin
      db52_ff <= pins_i.multi_pin_52 ? step5(db52_ff) : 5'h00;
      db55_ff <= pins_i.multi_pin_55 ? step5(db55_ff) : 5'h00;
      db_btn_ff <= pins_i.pushbutton_input ? step5(db_btn_ff) : 5'h00;
      hi52_ff <= pins_i.multi_pin_52 && (hi52_ff || db52_ff == 5'(DEBOUNCE_SAMPLES - 1));
      hi55_ff <= pins_i.multi_pin_55 && (hi55_ff || db55_ff == 5'(DEBOUNCE_SAMPLES - 1));
      hi_btn_ff <= pins_i.pushbutton_input &&
                   (hi_btn_ff || db_btn_ff == 5'(DEBOUNCE_SAMPLES - 1));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pin4_prev_ff <= 1'b0;
      serial_prev_ff <= 1'b0;
      optical_prev_ff <= 1'b0;
    end else begin
      pin4_prev_ff <= pins_i.multi_pin_4;
      serial_prev_ff <= pins_i.serial_receive;
      optical_prev_ff <= pins_i.optical_receive_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake events

  assign ev_pin4 = enables_ff[EN_PIN4] && pin_cfg_i.pin4_digital_in &&
                   pins_i.multi_pin_4 && !pin4_prev_ff;
  assign ev_pin52 = enables_ff[EN_PIN52] && pin_cfg_i.pin52_digital_in && hi52_ff;
  assign ev_pin55 = enables_ff[EN_PIN55] && (pin_cfg_i.optical_receive_disable ?
                    (pin_cfg_i.pin55_digital_in && hi55_ff) :
                    (pins_i.optical_receive_input != optical_prev_ff));
  assign ev_button = enables_ff[EN_BUTTON] && hi_btn_ff;
  // either edge taken: the wider reading never misses a rising edge
  assign ev_serial = enables_ff[EN_SERIAL] &&
                     (pins_i.serial_receive != serial_prev_ff);
  assign ev_timer = timer_run_ff && timer_secs_ff == 8'h00 &&
                    sec_cnt_ff == 26'(SEC_CYCLES - 1);
  assign any_wake = ev_pin4 || ev_pin52 || ev_pin55 || ev_button || ev_serial || ev_timer;
  assign resume_fall = resume_ff && sleep_req;

  ////////////////////////////////////////////////////////////////////////////
  // wake timer: counts value+1 seconds once armed and sleep requested

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      timer_run_ff <= 1'b0;
      timer_secs_ff <= 8'h00;
      sec_cnt_ff <= 26'h0000000;
    end else if (sleep_req && (arm_ff || wdata_i[MC_ARM])) begin
      timer_run_ff <= 1'b1;
      timer_secs_ff <= timer_value_ff;
      sec_cnt_ff <= 26'h0000000;
    end else if (timer_run_ff) begin
      if (sec_cnt_ff == 26'(SEC_CYCLES - 1)) begin
        sec_cnt_ff <= 26'h0000000;
        if (timer_secs_ff == 8'h00) begin
          timer_run_ff <= 1'b0;
        end else begin
          timer_secs_ff <= timer_secs_ff - 8'h01;
        end
      end else begin
        sec_cnt_ff <= sec_cnt_ff + 26'h0000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resume and processor release

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_AWAKE;
      resume_ff <= 1'b1;
      release_cnt_ff <= 12'h000;
    end else begin
      case (state_ff)
        ST_AWAKE: begin
          if (sleep_req) begin
            state_ff <= ST_ASLEEP;
            resume_ff <= 1'b0;
          end
        end
        ST_ASLEEP: begin
          if (any_wake) begin
            state_ff <= ST_RELEASING;
            resume_ff <= 1'b1;
            release_cnt_ff <= 12'h000;
          end
        end
        ST_RELEASING: begin
          // resume is already high here, so a sleep request must drop it too
          if (sleep_req) begin
            state_ff <= ST_ASLEEP;
            resume_ff <= 1'b0;
          end else if (release_cnt_ff == 12'(RELEASE_CYCLES - 1)) begin
            state_ff <= ST_AWAKE;
          end else begin
            release_cnt_ff <= release_cnt_ff + 12'h001;
          end
        end
        default: state_ff <= ST_AWAKE;
      endcase
    end
  end
  assign resume_o = resume_ff;
  assign cpu_release_o = (state_ff == ST_AWAKE);
  assign low_power_o = (state_ff == ST_ASLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // wake-cause flags; a new event wins over the clear on resume falling

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wake_flags_ff <= 6'h00;
    end else begin
      wake_flags_ff <= resume_fall ? 6'h00 : wake_flags_ff;
      if (ev_timer) wake_flags_ff[WC_TIMER] <= 1'b1;
      if (ev_serial) wake_flags_ff[WC_SERIAL] <= 1'b1;
      if (ev_button) wake_flags_ff[WC_BUTTON] <= 1'b1;
      if (!(enables_ff[EN_PIN4] && pin_cfg_i.pin4_digital_in)) begin
        wake_flags_ff[WC_PIN4] <= 1'b0;
      end else if (ev_pin4) begin
        wake_flags_ff[WC_PIN4] <= 1'b1;
      end
      if (!(enables_ff[EN_PIN52] && pin_cfg_i.pin52_digital_in)) begin
        wake_flags_ff[WC_PIN52] <= 1'b0;
      end else if (ev_pin52) begin
        wake_flags_ff[WC_PIN52] <= 1'b1;
      end
      if (!enables_ff[EN_PIN55]) begin
        wake_flags_ff[WC_PIN55] <= 1'b0;
      end else if (ev_pin55) begin
        wake_flags_ff[WC_PIN55] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset-cause flags, packed {cold,pin,soft,wdog,debug,batt}; survive reset_n_i

  assign dbg_rst = reset_src_i.debug_reset && debug_port_enable_pin_i;

  // a source pulse landing with resume falling still sets its flag
  always_ff @(posedge mclk_i) begin
    if (reset_src_i.cold_start) begin
      reset_flags_ff[5] <= 1'b1;
    end else if (resume_fall || reset_src_i.soft_reset || reset_src_i.watchdog ||
                 reset_src_i.low_battery || reset_src_i.reset_pin) begin
      reset_flags_ff[5] <= 1'b0;
    end
    if (reset_src_i.reset_pin) begin
      reset_flags_ff[4] <= 1'b1;
    end else if (resume_fall || reset_src_i.cold_start || reset_src_i.soft_reset ||
                 reset_src_i.watchdog || reset_src_i.low_battery) begin
      reset_flags_ff[4] <= 1'b0;
    end
    if (reset_src_i.soft_reset) begin
      reset_flags_ff[3] <= 1'b1;
    end else if (resume_fall || reset_src_i.cold_start || reset_src_i.watchdog ||
                 reset_src_i.low_battery || reset_src_i.reset_pin) begin
      reset_flags_ff[3] <= 1'b0;
    end
    if (reset_src_i.watchdog) begin
      reset_flags_ff[2] <= 1'b1;
    end else if (resume_fall || reset_src_i.cold_start || reset_src_i.soft_reset ||
                 reset_src_i.low_battery || reset_src_i.reset_pin) begin
      reset_flags_ff[2] <= 1'b0;
    end
    if (dbg_rst) begin
      reset_flags_ff[1] <= 1'b1;
    end else if (resume_fall || reset_src_i.cold_start || reset_src_i.reset_pin ||
                 reset_src_i.watchdog || reset_src_i.soft_reset) begin
      reset_flags_ff[1] <= 1'b0;
    end
    if (reset_src_i.low_battery) begin
      reset_flags_ff[0] <= 1'b1;
    end else if (resume_fall) begin
      reset_flags_ff[0] <= 1'b0;
    end
  end
endmodule : wsf_top

// ==== tb/tb_wake_source_flag_logic.sv ====
// bench: register reads/writes, reset-cause pulses and wake/sleep cycles
// assumes wsf_top with its package defaults and the pin model as far side
`timescale 1ns/1ps
module tb_wake_source_flag_logic;
  import wsf_pkg::*;
  logic mclk_i, reset_n_i, wr_i, rd_i;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic resume_o, cpu_release_o, low_power_o, dbg_en;
  wsf_reset_src_type src;
  wsf_pins_type pins;
  wsf_pin_cfg_type pin_cfg_i;
  int err_count = 0;
  int n_compared = 0;
  int k_t[11] = '{5, 1, 1, 0, 0, 5, 4, 4, 5, 5, 5};
  logic [3:0] cfg_t[11] = '{4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'h6, 4'hE, 4'hE};
  logic [7:0] f_t[11] = '{8'h04, 8'h10, 8'h10, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h04};
  logic [7:0] rc_m[6] = '{8'hF4, 8'h08, 8'hF8, 8'hF8, 8'hF8, 8'hF8};
  logic [7:0] rc_v[6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  wsf_top DUT (.mclk_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .reset_src_i(src), .debug_port_enable_pin_i(dbg_en), .pins_i(pins), .pin_cfg_i,
    .resume_o, .cpu_release_o, .low_power_o);
  wsf_pins_model u_far (.mclk_i, .pins_o(pins), .src_o(src), .dbg_en_o(dbg_en));
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge mclk_i);
    wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge mclk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge mclk_i);
    rd_i = 1'b0;
    check(rdata_o & m, e, "read");
  endtask : rd
  task automatic conclude();
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {addr_i, wr_i, rd_i, wdata_i} = '0;
    pin_cfg_i = 4'hE;
    reset_n_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    reset_n_i = 1'b1;
    rd(ADDR_WAKE_EN, 8'hFF, 8'h00);
    rd(ADDR_MODE_ARM, 8'hFF, 8'h00);
    rd(ADDR_WAKE_CAUSE, 8'hFF, 8'h00);
    rd(16'h28B4, 8'hFF, 8'h00);
    wr(ADDR_WAKE_EN, 8'hFF);
    rd(ADDR_WAKE_EN, 8'hFF, 8'h1F);
    wr(ADDR_WAKE_CAUSE, 8'hFF);
    rd(ADDR_WAKE_CAUSE, 8'hFF, 8'h00);
    wr(ADDR_MODE_ARM, 8'h20);
    rd(ADDR_MODE_ARM, 8'h20, 8'h20);
    u_far.pulse(5, 1'b1);
    u_far.pulse(1, 1'b0);
    rd(ADDR_RESET_CAUSE, 8'h08, 8'h00);
    for (int i = 5; i >= 0; i--) begin
      u_far.pulse(i, 1'b1);
      rd(ADDR_RESET_CAUSE, rc_m[i], rc_v[i]);
    end
    for (int i = 0; i < 11; i++) begin
      if (resume_o === 1'b1) begin
        wr(ADDR_MODE_ARM, 8'h80);
        check({6'h0, resume_o, low_power_o}, 8'h01, "sleep");
        rd(ADDR_WAKE_CAUSE, 8'hFF, 8'h00);
        rd(ADDR_RESET_CAUSE, 8'hFF, 8'h00);
      end
      pin_cfg_i = cfg_t[i];
      u_far.flip(k_t[i]);
      repeat (8) @(negedge mclk_i);
      check({7'h0, resume_o}, {7'h0, f_t[i] != 8'h00}, "wake");
      if (f_t[i] != 8'h00)
        rd(ADDR_WAKE_CAUSE, 8'hFD, f_t[i]);
    end
    repeat (RELEASE_CYCLES - 20) @(negedge mclk_i);
    check({7'h0, cpu_release_o}, 8'h00, "early release");
    repeat (30) @(negedge mclk_i);
    check({7'h0, cpu_release_o}, 8'h01, "release");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    conclude();
  end
endmodule : tb_wake_source_flag_logic

// ==== tb/wsf_chk.sv ====
// checker: register map, reset-cause and resume relations at the wsf_top ports
// assumes one mclk_i domain with a synchronous active-low reset
`timescale 1ns/1ps
module wsf_chk import wsf_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire wsf_reset_src_type reset_src_i,
  input wire logic debug_port_enable_pin_i,
  input wire logic resume_o,
  input wire logic cpu_release_o,
  input wire logic low_power_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic rd_rc;
  logic mapped;
  assign rd_rc = rd_i && addr_i == ADDR_RESET_CAUSE;
  assign mapped = addr_i inside {[ADDR_RESET_CAUSE:ADDR_WAKE_EN], ADDR_TIMER_VALUE};
  ////////////////////////////////////////////////////////////////////////////////
  // a lone source pulse, then a read: its bit set and the listed others cleared
  property p_rc(logic src, logic [7:0] m, logic [7:0] v);
    src ##2 rd_rc |=> (rdata_o & m) == v;
  endproperty
  a_rc_cold: assert property (p_rc(reset_src_i.cold_start, 8'hF8, 8'h80))
    else $error("cold start flag pattern wrong");
  a_rc_pin: assert property (p_rc(reset_src_i.reset_pin, 8'hF8, 8'h40))
    else $error("reset pin flag pattern wrong");
  a_rc_soft: assert property (p_rc(reset_src_i.soft_reset, 8'hF8, 8'h20))
    else $error("soft reset flag pattern wrong");
  a_rc_wdog: assert property (p_rc(reset_src_i.watchdog, 8'hF8, 8'h10))
    else $error("watchdog flag pattern wrong");
  a_rc_batt: assert property (p_rc(reset_src_i.low_battery, 8'hF4, 8'h04))
    else $error("low battery flag pattern wrong");
  property p_sleep;
    wr_i && addr_i == ADDR_MODE_ARM && (wdata_i[MC_SLEEP] || wdata_i[MC_DISPLAY]) && resume_o
      |=> !resume_o && low_power_o && !cpu_release_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request did not drop resume");
  property p_release;
    $rose(resume_o) |-> !cpu_release_o [*8];
  endproperty
  a_release: assert property (p_release)
    else $error("processor released too early");
  property p_run_awake;
    cpu_release_o |-> resume_o;
  endproperty
  a_run_awake: assert property (p_run_awake)
    else $error("processor runs without resume");
  property p_unmapped;
    rd_i && !mapped |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_en_rb;
    wr_i && addr_i == ADDR_WAKE_EN ##2 rd_i && addr_i == ADDR_WAKE_EN
      |=> rdata_o == {3'h0, $past(wdata_i[4:0], 3)};
  endproperty
  a_en_rb: assert property (p_en_rb)
    else $error("enable read-back wrong");
  c_wake: cover property ($rose(resume_o));
  c_release: cover property ($rose(cpu_release_o));
  c_rc_read: cover property (rd_rc);
endmodule : wsf_chk
bind wsf_top wsf_chk u_chk (.mclk_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
  .reset_src_i, .debug_port_enable_pin_i, .resume_o, .cpu_release_o, .low_power_o);

// ==== tb/wsf_pins_model.sv ====
// far side: wake pins and reset-source pulses of the board and firmware
// assumes the bench calls its tasks; all changes land on falling edges
`timescale 1ns/1ps
module wsf_pins_model import wsf_pkg::*; (
  input wire logic mclk_i,
  output wsf_pins_type pins_o,
  output wsf_reset_src_type src_o,
  output logic dbg_en_o
);
  initial begin
    pins_o = '0;
    src_o = '0;
    dbg_en_o = 1'b0;
  end
  // debug port enable set to dbg a cycle before the reset pulse and held there through it
  task automatic pulse(input int idx, input logic dbg);
    @(negedge mclk_i);
    dbg_en_o = dbg;
    @(negedge mclk_i);
    src_o[idx] = 1'b1;
    @(negedge mclk_i);
    src_o = '0;
  endtask : pulse
  // pins are plain levels; a flip gives one edge and then holds
  task automatic flip(input int idx);
    @(negedge mclk_i);
    pins_o[idx] = ~pins_o[idx];
  endtask : flip
endmodule : wsf_pins_model
